// file: rtl/psc_pkg.sv
// shared constants for the pattern source, capture and scan block
package psc_pkg;
  // ****************************
  // sizes
  // ****************************
  localparam int PINS = 32;
  localparam int SITES = 8;
  localparam int LANES = 4;
  localparam int WAVES = 512;
  localparam int MEM_WORDS = 256;
  // ****************************
  // vector opcodes
  // ****************************
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SRC_START = 3'h1;
  localparam logic [2:0] OP_SRC = 3'h2;
  localparam logic [2:0] OP_SRC_REPLACE = 3'h3;
  localparam logic [2:0] OP_CAP_START = 3'h4;
  localparam logic [2:0] OP_CAP = 3'h5;
  localparam logic [2:0] OP_CAP_STOP = 3'h6;
  localparam logic [2:0] OP_SCAN = 3'h7;
  // ****************************
  // pin states per vector
  // ****************************
  localparam logic [2:0] ST_DRIVE0 = 3'h0;
  localparam logic [2:0] ST_DRIVE1 = 3'h1;
  localparam logic [2:0] ST_EXP_LOW = 3'h2;
  localparam logic [2:0] ST_EXP_HIGH = 3'h3;
  localparam logic [2:0] ST_DONT_CARE = 3'h4;
  localparam logic [2:0] ST_FROM_SOURCE = 3'h5;
  localparam logic [2:0] ST_TO_CAPTURE = 3'h6;
  localparam logic [2:0] ST_MIDBAND = 3'h7;
  // ****************************
  // register offsets
  // ****************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WIDTH = 8'h04;
  localparam logic [7:0] REG_PINS = 8'h08;
  localparam logic [7:0] REG_SRC_DESC = 8'h0C;
  localparam logic [7:0] REG_CAP_DESC = 8'h10;
  localparam logic [7:0] REG_MEM_ADDR = 8'h14;
  localparam logic [7:0] REG_SRC_DATA = 8'h18;
  localparam logic [7:0] REG_CAP_DATA = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  // ****************************
  // field positions
  // ****************************
  localparam int CTRL_SRC_PAR = 0;
  localparam int CTRL_CAP_PAR = 1;
  localparam int CTRL_BCAST = 2;
  localparam int CTRL_SITE_EN = 8;
  localparam int WIDTH_CAP = 8;
  localparam int PINS_CAP = 8;
  localparam int PINS_SCAN_IN = 16;
  localparam int PINS_SCAN_OUT = 24;
  localparam int DESC_BASE = 16;
  localparam int STAT_SCAN_ERR = 3;
  localparam int STAT_CAP_PTR = 8;
  localparam logic [31:0] NO_SCAN_CYCLE = 32'hFFFFFFFF;
endpackage : psc_pkg

// file: rtl/pattern_source_capture_scan.sv
// source, capture and scan engine for a vector pattern instrument
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pattern_source_capture_scan
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic vec_valid,
  output logic vec_ready,
  input wire logic [2:0] vec_opcode,
  input wire logic [15:0] vec_operand,
  input wire logic [3*PINS-1:0] vec_state,
  input wire logic scan_data_in,
  input wire logic [PINS-1:0] above_high_compare_threshold,
  input wire logic [PINS-1:0] above_low_compare_threshold,
  output logic [PINS-1:0] pin_drive,
  output logic [PINS-1:0] pin_drive_en,
  output logic hist_valid,
  output logic [31:0] hist_scan_cycle
);
  // ****************************
  // state
  // ****************************
  typedef struct packed {
    logic src_par;
    logic cap_par;
    logic bcast;
    logic [SITES-1:0] site_en;
    logic [2:0] src_w;
    logic [2:0] cap_w;
    logic [1:0] src_pin;
    logic [1:0] cap_pin;
    logic [4:0] scan_in_pin;
    logic [4:0] scan_out_pin;
    logic [7:0] mem_addr;
    logic src_active;
    logic [7:0] src_ptr;
    logic [1:0] src_bit;
    logic cap_active;
    logic [7:0] cap_ptr;
    logic [1:0] cap_bit;
    logic [31:0] cap_acc;
    logic [PINS-1:0] drive;
    logic [PINS-1:0] drive_en;
    logic scan_busy;
    logic [15:0] scan_cnt;
    logic [15:0] scan_last;
    logic scan_err;
    logic hist_valid;
    logic [31:0] hist_cycle;
    logic [31:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;

  logic [7:0] src_desc [WAVES];
  logic [7:0] cap_desc [WAVES];
  logic [31:0] src_mem [MEM_WORDS];
  logic [31:0] cap_mem [MEM_WORDS];

  logic take;
  logic [31:0] src_word;
  logic [1:0] src_last;
  logic [1:0] cap_last;
  logic [PINS-1:0] src_use;
  logic [PINS-1:0] src_val;
  logic [PINS-1:0] cap_val;
  logic [PINS-1:0] fixed_use;
  logic [PINS-1:0] fixed_val;
  logic [31:0] cap_nib;
  logic cap_we;
  logic [31:0] cap_wdata;

  assign take = vec_valid & vec_ready;
  assign vec_ready = ~s.scan_busy;
  assign src_word = src_mem[s.src_ptr];
  // zero or above four means full nibble
  assign src_last = (s.src_w == 3'h0 || s.src_w > 3'h4) ? 2'h3 : 2'(s.src_w - 3'h1);
  assign cap_last = (s.cap_w == 3'h0 || s.cap_w > 3'h4) ? 2'h3 : 2'(s.cap_w - 3'h1);

  // ****************************
  // per pin source and compare
  // ****************************
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    localparam int SITE = p / LANES;
    localparam logic [1:0] LANE = 2'(p % LANES);
    logic [2:0] st;
    logic [3:0] nib;
    assign st = vec_state[3*p+:3];
    // broadcast reads site zero's nibble for all
    assign nib = s.bcast ? src_word[3:0] : src_word[4*SITE+:4];
    assign src_val[p] = s.src_par ? nib[LANE] : nib[s.src_bit];
    assign src_use[p] = s.site_en[SITE] & (st == ST_FROM_SOURCE)
                        & (s.src_par | (LANE == s.src_pin));
    // one only above both thresholds, midband gives zero
    assign cap_val[p] = s.site_en[SITE] & (st == ST_TO_CAPTURE)
                        & above_high_compare_threshold[p]
                        & above_low_compare_threshold[p];
    assign fixed_use[p] = (st == ST_DRIVE0) | (st == ST_DRIVE1);
    assign fixed_val[p] = (st == ST_DRIVE1);
  end

  // ****************************
  // per site capture nibble
  // ****************************
  for (genvar t = 0; t < SITES; t++) begin : g_site
    logic [3:0] v;
    assign v = cap_val[LANES*t+:LANES];
    assign cap_nib[4*t+:4] = s.cap_par ? v : {3'h0, v[s.cap_pin]};
  end

  // ****************************
  // next state
  // ****************************
  always_comb begin
    logic [1:0] sb;
    logic [31:0] acc;
    logic [PINS-1:0] sip;
    sb = 2'h0;
    acc = 32'h0;
    sip = PINS'(1) << s.scan_in_pin;
    next_s = s;
    next_s.hist_valid = 1'b0;
    next_s.rdata = 32'h0;
    cap_we = 1'b0;
    cap_wdata = 32'h0;
    // register writes
    if (reg_write) begin
      if (reg_addr == REG_CTRL) begin
        next_s.src_par = reg_wdata[CTRL_SRC_PAR];
        next_s.cap_par = reg_wdata[CTRL_CAP_PAR];
        next_s.bcast = reg_wdata[CTRL_BCAST];
        next_s.site_en = reg_wdata[CTRL_SITE_EN+:SITES];
      end else if (reg_addr == REG_WIDTH) begin
        next_s.src_w = reg_wdata[2:0];
        next_s.cap_w = reg_wdata[WIDTH_CAP+:3];
      end else if (reg_addr == REG_PINS) begin
        next_s.src_pin = reg_wdata[1:0];
        next_s.cap_pin = reg_wdata[PINS_CAP+:2];
        next_s.scan_in_pin = reg_wdata[PINS_SCAN_IN+:5];
        next_s.scan_out_pin = reg_wdata[PINS_SCAN_OUT+:5];
      end else if (reg_addr == REG_MEM_ADDR) begin
        next_s.mem_addr = reg_wdata[7:0];
      end else if (reg_addr == REG_SRC_DATA) begin
        next_s.mem_addr = s.mem_addr + 8'h1;
      end else if (reg_addr == REG_STATUS && reg_wdata[STAT_SCAN_ERR]) begin
        next_s.scan_err = 1'b0;
      end
    end
    // register reads, data in the following cycle
    if (reg_read) begin
      if (reg_addr == REG_CTRL) begin
        next_s.rdata = {16'h0, s.site_en, 5'h0, s.bcast, s.cap_par, s.src_par};
      end else if (reg_addr == REG_WIDTH) begin
        next_s.rdata = {21'h0, s.cap_w, 5'h0, s.src_w};
      end else if (reg_addr == REG_PINS) begin
        next_s.rdata = {3'h0, s.scan_out_pin, 3'h0, s.scan_in_pin,
                        6'h0, s.cap_pin, 6'h0, s.src_pin};
      end else if (reg_addr == REG_MEM_ADDR) begin
        next_s.rdata = {24'h0, s.mem_addr};
      end else if (reg_addr == REG_CAP_DATA) begin
        next_s.rdata = cap_mem[s.mem_addr];
      end else if (reg_addr == REG_STATUS) begin
        next_s.rdata = {16'h0, s.cap_ptr, 4'h0, s.scan_err, s.scan_busy,
                        s.cap_active, s.src_active};
      end
    end
    // scan cycles after the first, other pins hold
    if (s.scan_busy) begin
      next_s.drive = (s.drive & ~sip) | ({PINS{scan_data_in}} & sip);
      next_s.hist_valid = 1'b1;
      next_s.hist_cycle = 32'(s.scan_cnt);
      next_s.scan_cnt = s.scan_cnt + 16'h1;
      if (s.scan_cnt == s.scan_last) begin
        next_s.scan_busy = 1'b0;
      end
    end
    if (take) begin
      next_s.hist_valid = 1'b1;
      next_s.hist_cycle = NO_SCAN_CYCLE;
      // plain drive states apply on every vector
      next_s.drive = (s.drive & ~fixed_use) | (fixed_val & fixed_use);
      next_s.drive_en = (s.drive_en & ~fixed_use) | fixed_use;
      case (vec_opcode)
        OP_SRC_START, OP_CAP_START: begin
          // start from the descriptor's first sample
          if (vec_opcode == OP_SRC_START) begin
            next_s.src_active = 1'b1;
            next_s.src_ptr = src_desc[vec_operand[8:0]];
            next_s.src_bit = 2'h0;
          end else begin
            next_s.cap_active = 1'b1;
            next_s.cap_ptr = cap_desc[vec_operand[8:0]];
            next_s.cap_bit = 2'h0;
            next_s.cap_acc = 32'h0;
          end
        end
        OP_SRC, OP_SRC_REPLACE: begin
          if (s.src_active) begin
            next_s.drive = (next_s.drive & ~src_use) | (src_val & src_use);
            next_s.drive_en = next_s.drive_en | src_use;
            // replace drives the current bit without consuming it
            if (vec_opcode == OP_SRC) begin
              if (s.src_par || s.src_bit == src_last) begin
                next_s.src_ptr = s.src_ptr + 8'h1;
                next_s.src_bit = 2'h0;
              end else begin
                next_s.src_bit = s.src_bit + 2'h1;
              end
            end
          end
        end
        OP_CAP: begin
          if (s.cap_active) begin
            if (s.cap_par) begin
              cap_we = 1'b1;
              cap_wdata = cap_nib;
              next_s.cap_ptr = s.cap_ptr + 8'h1;
            end else begin
              sb = s.cap_bit;
              for (int t = 0; t < SITES; t++) begin
                acc[4*t+:4] = s.cap_acc[4*t+:4] | ({3'h0, cap_nib[4*t]} << sb);
              end
              if (s.cap_bit == cap_last) begin
                cap_we = 1'b1;
                cap_wdata = acc;
                next_s.cap_ptr = s.cap_ptr + 8'h1;
                next_s.cap_bit = 2'h0;
                next_s.cap_acc = 32'h0;
              end else begin
                next_s.cap_bit = s.cap_bit + 2'h1;
                next_s.cap_acc = acc;
              end
            end
          end
        end
        OP_CAP_STOP: begin
          next_s.cap_active = 1'b0;
        end
        OP_SCAN: begin
          // scan vector: first scan cycle is this one
          next_s.hist_cycle = 32'h0;
          next_s.drive = (next_s.drive & ~sip) | ({PINS{scan_data_in}} & sip);
          next_s.drive_en = next_s.drive_en | sip;
          next_s.scan_cnt = 16'h1;
          next_s.scan_last = vec_operand - 16'h1;
          next_s.scan_busy = (vec_operand > 16'h1);
          if (!fixed_use[s.scan_in_pin]) begin
            next_s.scan_err = 1'b1;
          end
          if (vec_state[3*s.scan_out_pin+:3] != ST_EXP_LOW
              && vec_state[3*s.scan_out_pin+:3] != ST_EXP_HIGH
              && vec_state[3*s.scan_out_pin+:3] != ST_DONT_CARE) begin
            next_s.scan_err = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************
  // registers and memories
  // ****************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // descriptor and sample memories
  always_ff @(posedge mclk) begin
    if (reg_write && reg_addr == REG_SRC_DESC) begin
      src_desc[reg_wdata[8:0]] <= reg_wdata[DESC_BASE+:8];
    end
    if (reg_write && reg_addr == REG_CAP_DESC) begin
      cap_desc[reg_wdata[8:0]] <= reg_wdata[DESC_BASE+:8];
    end
    if (reg_write && reg_addr == REG_SRC_DATA) begin
      src_mem[s.mem_addr] <= reg_wdata;
    end
    if (cap_we) begin
      cap_mem[s.cap_ptr] <= cap_wdata;
    end
  end

  assign reg_rdata = s.rdata;
  assign pin_drive = s.drive;
  assign pin_drive_en = s.drive_en;
  assign hist_valid = s.hist_valid;
  assign hist_scan_cycle = s.hist_cycle;

  // ****************************
  // checks
  // ****************************
  serial_shift_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_SRC && s.src_active && !s.src_par && s.src_bit != src_last
    |=> s.src_bit == $past(s.src_bit) + 2'h1 && s.src_ptr == $past(s.src_ptr))
    else $error("serial source bit did not step");
  serial_advance_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_SRC && s.src_active && !s.src_par && s.src_bit == src_last
    |=> s.src_bit == 2'h0 && s.src_ptr == $past(s.src_ptr) + 8'h1)
    else $error("serial source sample did not advance");
  parallel_source_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_SRC && s.src_active && s.src_par && src_use[0]
    |=> pin_drive_en[0] && pin_drive[0] == $past(src_val[0]))
    else $error("parallel source bit not driven");
  no_wave_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_SRC && !s.src_active && fixed_use == '0
    |=> $stable(pin_drive) && $stable(s.src_ptr))
    else $error("source without waveform changed pins");
  start_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_CAP_START
    |=> s.cap_active && s.cap_bit == 2'h0 && s.cap_acc == 32'h0)
    else $error("capture start did not reload");
  cap_close_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode == OP_CAP && s.cap_active && !s.cap_par && s.cap_bit == cap_last
    |-> cap_we ##1 s.cap_ptr == $past(s.cap_ptr) + 8'h1)
    else $error("serial capture sample did not close");
  cap_open_a: assert property (@(posedge mclk) disable iff (!resetn)
    cap_we |-> s.cap_active && take && vec_opcode == OP_CAP)
    else $error("capture write outside open waveform");
  hist_plain_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && vec_opcode != OP_SCAN |=> hist_valid && hist_scan_cycle == NO_SCAN_CYCLE)
    else $error("non scan cycle history not minus one");
  scan_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    s.scan_busy |-> !vec_ready ##1 pin_drive_en == $past(pin_drive_en))
    else $error("pins moved during scan vector");
endmodule : pattern_source_capture_scan

// file: testbench/dut_pin_model.sv
// comparator-side model of the device under test sitting on the pins
`timescale 1ns/1ps
module dut_pin_model
  import psc_pkg::*;
(
  input wire logic [PINS-1:0] pin_drive,
  input wire logic [PINS-1:0] pin_drive_en,
  input wire logic [PINS-1:0] dut_level,
  input wire logic [PINS-1:0] dut_mid,
  output logic [PINS-1:0] above_high_compare_threshold,
  output logic [PINS-1:0] above_low_compare_threshold
);
  // ****************************
  // pin voltage against both thresholds
  // ****************************
  // driven pins follow the instrument; midband sits between the two thresholds
  always_comb begin
    above_high_compare_threshold = (pin_drive_en & pin_drive)
                                 | (~pin_drive_en & dut_level & ~dut_mid);
    above_low_compare_threshold = (pin_drive_en & pin_drive)
                                | (~pin_drive_en & (dut_level | dut_mid));
  end
endmodule : dut_pin_model

// file: testbench/pattern_source_capture_scan_tb_top.sv
// self-checking bench for the source, capture and scan block
`timescale 1ns/1ps
module pattern_source_capture_scan_tb_top;
  import psc_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic vec_valid = 1'b0;
  logic vec_ready;
  logic [2:0] vec_opcode = 3'h0;
  logic [15:0] vec_operand = 16'h0;
  logic [3*PINS-1:0] vec_state = '0;
  logic [3*PINS-1:0] st;
  logic scan_data_in = 1'b0;
  logic [PINS-1:0] ahi, alo, pin_drive, pin_drive_en;
  logic [PINS-1:0] dut_level = '0;
  logic [PINS-1:0] dut_mid = '0;
  logic hist_valid;
  logic [31:0] hist_scan_cycle;
  logic [31:0] seed = 32'd55304;
  logic [31:0] w [4];
  logic [31:0] cx [4];
  logic [31:0] lv, md, vm, c;
  logic [2:0] sbits;
  int n_mismatch = 0;
  int samples_checked = 0;

  // clock of 25 ns
  always #12.5 mclk = ~mclk;

  pattern_source_capture_scan dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .vec_valid(vec_valid), .vec_ready(vec_ready), .vec_opcode(vec_opcode),
    .vec_operand(vec_operand), .vec_state(vec_state), .scan_data_in(scan_data_in),
    .above_high_compare_threshold(ahi), .above_low_compare_threshold(alo),
    .pin_drive(pin_drive), .pin_drive_en(pin_drive_en), .hist_valid(hist_valid),
    .hist_scan_cycle(hist_scan_cycle)
  );

  dut_pin_model partner (
    .pin_drive(pin_drive), .pin_drive_en(pin_drive_en), .dut_level(dut_level),
    .dut_mid(dut_mid), .above_high_compare_threshold(ahi), .above_low_compare_threshold(alo)
  );

  // ****************************
  // helpers and bus tasks
  // ****************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [3*PINS-1:0] all_st(input logic [2:0] s);
    return {PINS{s}};
  endfunction : all_st

  // one lane of every site, and a broadcast bit spread over lane 2
  function automatic logic [31:0] lane_mask(input int lane);
    return 32'h11111111 << lane;
  endfunction : lane_mask

  function automatic logic [31:0] bcast_bit(input logic [31:0] word, input int k);
    return word[k] ? lane_mask(2) : 32'h0;
  endfunction : bcast_bit

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, want);
  endtask : rdc

  // one vector, taken at the second edge; returns with its results settled
  task automatic vec(input logic [2:0] op, input logic [15:0] arg, input logic [3*PINS-1:0] s);
    @(posedge mclk);
    vec_valid <= 1'b1;
    vec_opcode <= op;
    vec_operand <= arg;
    vec_state <= s;
    @(posedge mclk);
    vec_valid <= 1'b0;
    #1;
  endtask : vec

  // mid-run reset: pins released, config cleared, memories kept
  task automatic pulse_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk(pin_drive_en, 32'h0);
    chk(hist_valid, 32'h0);
    wr(REG_PINS, 32'h07030102);
  endtask : pulse_reset

  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end

  // ****************************
  // scenarios
  // ****************************
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    // parallel, site unique; source before any start drives nothing
    wr(REG_CTRL, 32'h0000FF01);
    wr(REG_PINS, 32'h07030102);
    vec(OP_SRC, 16'h0, all_st(ST_FROM_SOURCE));
    chk(pin_drive_en, 32'h0);
    wr(REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w[i] = rnd();
      wr(REG_SRC_DATA, w[i]);
    end
    wr(REG_SRC_DESC, 32'h000001FF);
    wr(REG_SRC_DESC, 32'h00020005);
    vec(OP_SRC_START, 16'h01FF, all_st(ST_DONT_CARE));
    vec(OP_SRC, 16'h0, all_st(ST_FROM_SOURCE));
    chk(pin_drive, w[0]);
    chk(pin_drive_en, 32'hFFFFFFFF);
    chk(hist_valid, 32'h1);
    chk(hist_scan_cycle, NO_SCAN_CYCLE);
    vec(OP_SRC_REPLACE, 16'h0, all_st(ST_FROM_SOURCE));
    chk(pin_drive, w[1]);
    vec(OP_SRC, 16'h0, all_st(ST_FROM_SOURCE));
    chk(pin_drive, w[1]);
    vec(OP_SRC_START, 16'h0005, all_st(ST_DONT_CARE));
    vec(OP_SRC, 16'h0, all_st(ST_FROM_SOURCE));
    chk(pin_drive, w[2]);
    pulse_reset();
    // serial broadcast, width 3 on lane 2
    wr(REG_CTRL, 32'h0000FF04);
    wr(REG_WIDTH, 32'h00000003);
    vec(OP_SRC_START, 16'h0005, all_st(ST_DONT_CARE));
    st = all_st(ST_DONT_CARE);
    for (int s = 0; s < SITES; s++) begin
      st[3*(4*s+2) +: 3] = ST_FROM_SOURCE;
    end
    for (int k = 0; k < 4; k++) begin
      vec(OP_SRC, 16'h0, st);
      chk(pin_drive & lane_mask(2), bcast_bit(w[2 + k/3], k % 3));
      chk(pin_drive_en, lane_mask(2));
    end
    pulse_reset();
    // capture: parallel then serial width 2 on lane 1
    wr(REG_WIDTH, 32'h00000200);
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, m ? 32'h0000FF00 : 32'h0000FF02);
      wr(REG_CAP_DESC, m ? 32'h00200007 : 32'h0010012C);
      vec(OP_CAP_START, m ? 16'h0007 : 16'h012C, all_st(ST_DONT_CARE));
      cx = '{default: 32'h0};
      for (int k = 0; k < 4; k++) begin
        lv = rnd();
        md = rnd();
        vm = rnd();
        dut_level <= lv;
        dut_mid <= md;
        for (int p = 0; p < PINS; p++) begin
          st[3*p +: 3] = vm[p] ? ST_TO_CAPTURE : ST_MIDBAND;
        end
        vec(OP_CAP, 16'h0, st);
        c = lv & ~md & vm;
        for (int s = 0; s < SITES; s++) begin
          if (m == 0) begin
            cx[k] = c;
          end else begin
            cx[k/2][4*s + k%2] = c[4*s+1];
          end
        end
      end
      vec(OP_CAP_STOP, 16'h0, all_st(ST_DONT_CARE));
      for (int k = 0; k < (m ? 2 : 4); k++) begin
        wr(REG_MEM_ADDR, (m ? 32'h20 : 32'h10) + k);
        rdc(REG_CAP_DATA, cx[k], 32'hFFFFFFFF);
      end
    end
    // scan of three cycles: scan-in pin 3 plays data, others hold
    sbits = 3'(rnd());
    st = all_st(ST_DRIVE1);
    st[9 +: 3] = ST_DRIVE0;
    st[21 +: 3] = ST_DONT_CARE;
    scan_data_in <= sbits[0];
    vec(OP_SCAN, 16'h0003, st);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        @(posedge mclk);
        #1;
      end
      scan_data_in <= sbits[(k + 1) % 3];
      chk(hist_scan_cycle, k);
      chk(pin_drive[3], sbits[k]);
      chk(pin_drive[0], 32'h1);
      chk(vec_ready, k == 2);
    end
    // illegal states count only on scan vectors
    for (int b = 0; b < 2; b++) begin
      st = all_st(ST_DRIVE1);
      st[3*(b ? 7 : 3) +: 3] = b ? ST_DRIVE0 : ST_EXP_LOW;
      vec(OP_NONE, 16'h0, st);
      rdc(REG_STATUS, 32'h0, 32'h8);
      vec(OP_SCAN, 16'h0001, st);
      rdc(REG_STATUS, 32'h8, 32'h8);
      wr(REG_STATUS, 32'h8);
    end
    finish_test();
  end
endmodule : pattern_source_capture_scan_tb_top
